// file: hdl/imbg_top.sv
// serial port master: baud generation, start/stop/byte sequencing, APB regs
// assumes open-drain SCL/SDA resolved outside; pins are asynchronous
`timescale 1ns/1ps
module imbg_top
  import imbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  imbg_state_t st_q;
  logic [1:0] step_q;
  logic hi_q;
  logic [3:0] nb_q;
  logic [8:0] sh_q;
  logic rx_q;
  logic ack_q;
  logic scl_lo_q;
  logic sda_lo_q;
  logic done_q;
  logic [7:0] sts_q;
  logic [7:0] con1_q;
  logic [7:0] con2_q;
  logic [7:0] con3_q;
  logic [7:0] mask_q;
  logic [7:0] reload_q;
  logic [7:0] buf_q;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic scl_out_q;
  logic scl_oe_n_q;
  logic sda_out_q;
  logic sda_oe_n_q;
  logic [2:0] sync_q [2];
  logic [1:0] pin_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [1:0] pin_raw = {sda_in, scl_in};

  // a level counts once the second and third stage agree
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_q[i] <= 3'h7;
          pin_q[i] <= 1'b1;
        end
        else
        begin
          sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
          if (sync_q[i][1] == sync_q[i][2])
            pin_q[i] <= sync_q[i][2];
        end
      end
    end
  endgenerate

  wire scl_f = pin_q[0];
  wire sda_f = pin_q[1];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire mapped = hit(paddr, A_STATUS) | hit(paddr, A_CON1) | hit(paddr, A_CON2)
    | hit(paddr, A_CON3) | hit(paddr, A_MASK) | hit(paddr, A_RELOAD)
    | hit(paddr, A_BUF) | hit(paddr, A_IRQ_STS) | hit(paddr, A_IRQ_EN)
    | hit(paddr, A_IRQ_CLR);
  wire [7:0] rd_byte = hit(paddr, A_STATUS) ? sts_q
    : hit(paddr, A_CON1) ? con1_q
    : hit(paddr, A_CON2) ? con2_q
    : hit(paddr, A_CON3) ? con3_q
    : hit(paddr, A_MASK) ? mask_q
    : hit(paddr, A_RELOAD) ? reload_q
    : hit(paddr, A_BUF) ? buf_q
    : hit(paddr, A_IRQ_STS) ? 8'(irq_sts_q)
    : hit(paddr, A_IRQ_EN) ? 8'(irq_en_q)
    : 8'h00;

  // ----------------------------------------------------------------
  // mode and command decode
  // ----------------------------------------------------------------
  wire spi_md = con1_q[CON1_EN] & (con1_q[3:0] == MODE_SPI);
  wire i2c_md = con1_q[CON1_EN] & (con1_q[3:0] == MODE_I2C);
  wire busy = (st_q != ST_IDLE) | (|con2_q[4:0]);
  wire buf_wr = wr & hit(paddr, A_BUF);
  wire buf_coll = buf_wr & busy;
  wire buf_go = buf_wr & ~busy & (spi_md | i2c_md);
  wire c2_lock = (st_q == ST_START);
  wire [4:0] c2_low = c2_lock ? con2_q[4:0] : pwdata[4:0];
  wire [7:0] c2_wv = {pwdata[7], con2_q[CON2_ACKSTAT], pwdata[5], c2_low};
  wire last = (nb_q == ACK_BITS);
  wire [8:0] sh_nx = {sh_q[7:0], sda_f};
  wire [IRQ_W-1:0] irq_ev = {buf_coll, done_q};
  wire irq_clr_wr = wr & hit(paddr, A_IRQ_CLR);

  // ----------------------------------------------------------------
  // baud counter
  // ----------------------------------------------------------------
  imbg_brg_if brg ();

  assign brg.run = (st_q != ST_IDLE);
  assign brg.reload = reload_q;
  assign brg.scl_rel = ~scl_lo_q & ~spi_md;
  assign brg.scl_hi = scl_f;

  wire tk = brg.tick;

  imbg_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .brg(brg)
  );

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // plain software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      con3_q <= RST_BYTE;
      mask_q <= RST_BYTE;
      reload_q <= RST_BYTE;
      irq_en_q <= '0;
    end
    else if (wr)
    begin
      if (hit(paddr, A_CON3))
        con3_q <= pwdata[7:0];
      if (hit(paddr, A_MASK))
        mask_q <= pwdata[7:0];
      if (hit(paddr, A_RELOAD))
        reload_q <= pwdata[7:0];
      if (hit(paddr, A_IRQ_EN))
        irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  // collision flag clears only by writing zero; a new collision wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      con1_q <= RST_BYTE;
    else
    begin
      if (wr & hit(paddr, A_CON1))
        con1_q <= {pwdata[7] & con1_q[CON1_WRITE_COLLISION_FLAG], pwdata[6:0]};
      if (buf_coll)
        con1_q[CON1_WRITE_COLLISION_FLAG] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_sts_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_sts_q <= (irq_sts_q & ~(irq_clr_wr ? pwdata[IRQ_W-1:0] : '0)) | irq_ev;
      irq_q <= |(irq_sts_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      step_q <= 2'h0;
      hi_q <= 1'b0;
      nb_q <= 4'h0;
      sh_q <= 9'h000;
      rx_q <= 1'b0;
      ack_q <= 1'b0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
      done_q <= 1'b0;
      con2_q <= RST_BYTE;
      sts_q <= RST_BYTE;
      buf_q <= RST_BYTE;
    end
    else
    begin
      done_q <= 1'b0;
      if (wr & hit(paddr, A_CON2))
        con2_q <= c2_wv;
      if (wr & hit(paddr, A_STATUS))
        sts_q[7:6] <= pwdata[7:6];
      if (buf_wr & ~busy)
        buf_q <= pwdata[7:0];
      if (rd & hit(paddr, A_BUF))
        sts_q[STAT_BF] <= 1'b0;
      unique case (st_q)
        ST_IDLE:
        begin
          step_q <= 2'h0;
          hi_q <= 1'b0;
          if (i2c_md & con2_q[CON2_SEN])
          begin
            st_q <= ST_START;
            sda_lo_q <= 1'b1;
          end
          else if (i2c_md & con2_q[CON2_RSEN])
          begin
            st_q <= ST_RSTART;
            sda_lo_q <= 1'b0;
          end
          else if (i2c_md & con2_q[CON2_PEN])
          begin
            st_q <= ST_STOP;
            sda_lo_q <= 1'b1;
          end
          else if (i2c_md & con2_q[CON2_RCEN])
          begin
            st_q <= ST_BITS;
            sh_q <= 9'h1FF;
            nb_q <= RX_BITS;
            rx_q <= 1'b1;
            ack_q <= 1'b0;
            sda_lo_q <= 1'b0;
          end
          else if (i2c_md & con2_q[CON2_ACKEN])
          begin
            st_q <= ST_BITS;
            sh_q <= {con2_q[CON2_ACKDT], 8'hFF};
            nb_q <= ACK_BITS;
            rx_q <= 1'b0;
            ack_q <= 1'b0;
            sda_lo_q <= ~con2_q[CON2_ACKDT];
          end
          else if (buf_go)
          begin
            st_q <= ST_BITS;
            sh_q <= {pwdata[7:0], 1'b1};
            nb_q <= spi_md ? SPI_BITS : TX_BITS;
            rx_q <= spi_md;
            ack_q <= ~spi_md;
            sda_lo_q <= ~pwdata[7];
            scl_lo_q <= 1'b1;
          end
        end
        ST_START:
        begin
          if (tk)
          begin
            scl_lo_q <= 1'b1;
            st_q <= ST_IDLE;
            con2_q[CON2_SEN] <= 1'b0;
            done_q <= 1'b1;
            sts_q[STAT_S] <= 1'b1;
            sts_q[STAT_P] <= 1'b0;
          end
        end
        ST_RSTART:
        begin
          if (tk)
          begin
            step_q <= step_q + 2'h1;
            if (step_q == 2'h0)
              scl_lo_q <= 1'b0;
            else if (step_q == 2'h1)
              sda_lo_q <= 1'b1;
            else
            begin
              scl_lo_q <= 1'b1;
              st_q <= ST_IDLE;
              con2_q[CON2_RSEN] <= 1'b0;
              done_q <= 1'b1;
              sts_q[STAT_S] <= 1'b1;
              sts_q[STAT_P] <= 1'b0;
            end
          end
        end
        ST_STOP:
        begin
          if (tk)
          begin
            step_q <= step_q + 2'h1;
            if (step_q == 2'h0)
              scl_lo_q <= 1'b0;
            else
            begin
              sda_lo_q <= 1'b0;
              st_q <= ST_IDLE;
              con2_q[CON2_PEN] <= 1'b0;
              done_q <= 1'b1;
              sts_q[STAT_P] <= 1'b1;
              sts_q[STAT_S] <= 1'b0;
            end
          end
        end
        ST_BITS:
        begin
          // low half ends by releasing the clock, high half by sampling
          if (tk & ~hi_q)
          begin
            scl_lo_q <= 1'b0;
            hi_q <= 1'b1;
          end
          else if (tk)
          begin
            sh_q <= sh_nx;
            nb_q <= nb_q - 4'h1;
            hi_q <= 1'b0;
            scl_lo_q <= 1'b1;
            sda_lo_q <= ~sh_q[7];
            if (last)
            begin
              st_q <= ST_IDLE;
              done_q <= 1'b1;
              sda_lo_q <= 1'b0;
              con2_q[CON2_RCEN] <= 1'b0;
              con2_q[CON2_ACKEN] <= 1'b0;
              if (ack_q)
                con2_q[CON2_ACKSTAT] <= sda_f;
              if (rx_q)
              begin
                buf_q <= sh_nx[7:0];
                sts_q[STAT_BF] <= 1'b1;
              end
            end
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_oe_n_q <= 1'b1;
      scl_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      sda_out_q <= 1'b0;
    end
    else
    begin
      scl_oe_n_q <= ~(spi_md | scl_lo_q);
      scl_out_q <= spi_md & ~scl_lo_q;
      sda_oe_n_q <= ~(spi_md | sda_lo_q);
      sda_out_q <= spi_md & ~sda_lo_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign scl_out = scl_out_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_write_collision_flag;
    @(posedge pclk) disable iff (!presetn)
    buf_coll && !(tk && st_q == ST_BITS) |=> con1_q[CON1_WRITE_COLLISION_FLAG] && $stable(buf_q);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged or buffer hit");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, A_CON2) && c2_lock && !tk |=> $stable(con2_q[4:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("control two changed during start");

  property p_auto;
    @(posedge pclk) disable iff (!presetn)
    buf_go && reload_q > 8'h02 |=> (st_q == ST_BITS && brg.run) [*3];
  endproperty
  a_auto: assert property (p_auto) else $error("buffer write did not start transfer");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_IDLE && !buf_go && !(|con2_q[4:0]) |=> $stable(scl_lo_q) && !tk;
  endproperty
  a_hold: assert property (p_hold) else $error("clock moved while idle");

endmodule

// file: hdl/imbg_pkg.sv
// constants, register map and state codes of the serial-port baud block
// assumes a 100 MHz pclk and an 8-bit register file behind APB
package imbg_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CON1 = 8'h04;
  localparam logic [7:0] A_CON2 = 8'h08;
  localparam logic [7:0] A_CON3 = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_RELOAD = 8'h14;
  localparam logic [7:0] A_BUF = 8'h18;
  localparam logic [7:0] A_IRQ_STS = 8'h1C;
  localparam logic [7:0] A_IRQ_EN = 8'h20;
  localparam logic [7:0] A_IRQ_CLR = 8'h24;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int CON1_WRITE_COLLISION_FLAG = 7;
  localparam int CON1_EN = 5;
  localparam logic [3:0] MODE_I2C = 4'h8;
  localparam logic [3:0] MODE_SPI = 4'hA;
  localparam int CON2_SEN = 0;
  localparam int CON2_RSEN = 1;
  localparam int CON2_PEN = 2;
  localparam int CON2_RCEN = 3;
  localparam int CON2_ACKEN = 4;
  localparam int CON2_ACKDT = 5;
  localparam int CON2_ACKSTAT = 6;
  localparam int STAT_BF = 0;
  localparam int STAT_S = 3;
  localparam int STAT_P = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // reset values and bit counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] TX_BITS = 4'h9;
  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] SPI_BITS = 4'h8;
  localparam logic [3:0] ACK_BITS = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BITS = 3'b011,
    ST_STOP = 3'b010,
    ST_RSTART = 3'b110
  } imbg_state_t;

endpackage

// file: hdl/imbg_brg_if.sv
// link between the sequencer and the baud counter
// assumes both ends run on pclk
`timescale 1ns/1ps
interface imbg_brg_if;
  logic run;
  logic [7:0] reload;
  logic scl_rel;
  logic scl_hi;
  logic tick;
  modport ctl (output run, output reload, output scl_rel, output scl_hi, input tick);
  modport cnt (input run, input reload, input scl_rel, input scl_hi, output tick);
endinterface

// file: hdl/imbg_baud.sv
// baud counter with clock arbitration
// assumes scl_hi is already synchronised to pclk
`timescale 1ns/1ps
module imbg_baud
  import imbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  imbg_brg_if.cnt brg
);

  logic pre_q;
  logic [7:0] cnt_q;
  logic seen_q;
  logic tick_q;

  // ----------------------------------------------------------------
  // count enable and rollover
  // ----------------------------------------------------------------
  wire pause = brg.scl_rel & ~seen_q;
  wire roll = brg.run & ~pause & pre_q & (cnt_q == 8'h00);

  assign brg.tick = tick_q;

  // counter steps every second pclk: two rollovers per clock period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 1'b0;
    else
      pre_q <= ~pre_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= RST_BYTE;
      seen_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= roll;
      if (!brg.run)
      begin
        cnt_q <= brg.reload;
        seen_q <= 1'b0;
      end
      else if (pause)
      begin
        if (brg.scl_hi)
        begin
          cnt_q <= brg.reload;
          seen_q <= 1'b1;
        end
      end
      else
      begin
        if (!brg.scl_rel)
          seen_q <= 1'b0;
        if (roll)
          cnt_q <= brg.reload;
        else if (pre_q)
          cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pause;
    @(posedge pclk) disable iff (!presetn)
    brg.run && pause && !brg.scl_hi |=> $stable(cnt_q) && !tick_q;
  endproperty
  a_pause: assert property (p_pause) else $error("counter moved while clock held low");

  property p_load;
    @(posedge pclk) disable iff (!presetn)
    brg.run && pause && brg.scl_hi |=> cnt_q == $past(brg.reload) && seen_q;
  endproperty
  a_load: assert property (p_load) else $error("no reload when clock seen high");

  property p_high;
    @(posedge pclk) disable iff (!presetn)
    brg.run && pause && brg.scl_hi && brg.reload > 8'h02 |=> !tick_q [*4];
  endproperty
  a_high: assert property (p_high) else $error("clock high phase cut short");

  property p_tick;
    @(posedge pclk) disable iff (!presetn)
    tick_q |-> cnt_q == $past(brg.reload);
  endproperty
  a_tick: assert property (p_tick) else $error("rollover without reload");

endmodule

// file: bench/imbg_slave_model.sv
// behavioural target on the two-wire link: counts bits, acks, stretches scl
// assumes resolved scl/sda wire levels and the bench pclk
`timescale 1ns/1ps
module imbg_slave_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] stretch,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] rx_byte
);
  logic scl_q;
  logic sda_q;
  logic [7:0] cnt_q;
  logic [3:0] bit_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      cnt_q <= 8'h00;
      bit_q <= 4'hF;
      rx_byte <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      // hold the clock low for stretch cycles after each falling edge
      if (scl_low)
      begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01)
          scl_low <= 1'b0;
      end
      else if (scl_q && !scl && stretch != 8'h00)
      begin
        scl_low <= 1'b1;
        cnt_q <= stretch;
      end
      if (scl && sda_q && !sda)
        bit_q <= 4'h0;
      else if (!scl_q && scl && bit_q < 4'h8)
      begin
        rx_byte <= {rx_byte[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end
      else if (scl_q && !scl && bit_q == 4'h8)
      begin
        sda_low <= 1'b1;
        bit_q <= 4'h9;
      end
      else if (scl_q && !scl && bit_q == 4'h9)
      begin
        sda_low <= 1'b0;
        bit_q <= 4'h0;
      end
    end
  end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the serial-port master over APB
// assumes open-drain wires with pull-ups, resolved here
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_top
  import imbg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, spi;
  logic [7:0] paddr, stretch, slv_rx;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, irq, e;
  logic slv_scl_low, slv_sda_low, scl_p;
  wire scl_w = spi ? scl_out : (scl_oe_n | scl_out) & !slv_scl_low;
  wire sda_w = spi ? sda_out : (sda_oe_n | sda_out) & !slv_sda_low;
  int fails, n_checks, run, cyc, rise_t, min_hi, min_lo, min_per, max_per, bad;
  logic [7:0] regs [9] = '{A_STATUS, A_CON1, A_CON2, A_CON3, A_MASK, A_RELOAD, A_BUF,
    A_IRQ_STS, A_IRQ_EN};

  imbg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
  imbg_slave_model slv (.pclk(pclk), .presetn(presetn), .scl(scl_w), .sda(sda_w),
    .stretch(stretch), .scl_low(slv_scl_low), .sda_low(slv_sda_low), .rx_byte(slv_rx));

  // ----------------------------------------------------------------
  // bus tasks and scl phase monitor
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    `CHK(r, 32'(x))
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
    `CHK(irq, 1'b1)
  endtask
  task automatic mon_clr();
    min_hi = 999;
    min_lo = 999;
    min_per = 999;
    max_per = 0;
    rise_t = 0;
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (scl_w === scl_p)
      run++;
    else
    begin
      if (scl_p && run < min_hi)
        min_hi = run;
      if (!scl_p && run < min_lo)
        min_lo = run;
      if (!scl_p && rise_t > 0)
      begin
        if (cyc - rise_t < min_per)
          min_per = cyc - rise_t;
        if (cyc - rise_t > max_per)
          max_per = cyc - rise_t;
      end
      if (!scl_p)
        rise_t = cyc;
      run = 1;
    end
    scl_p = scl_w;
  end

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    spi = 1'b0;
    stretch = 8'h00;
    mon_clr();
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    apb(1'b0, 8'h30, 8'h00);
    `CHK(e, 1'b1)
    wr(A_MASK, 8'hC3);
    rd(A_MASK, 8'hC3);
    wr(A_IRQ_STS, 8'hFF);
    rd(A_IRQ_STS, 8'h00);
    $display("test registers done");
    wr(A_RELOAD, 8'h03);
    wr(A_CON1, 8'h28);
    wr(A_IRQ_EN, 8'h01);
    wr(A_CON2, 8'h01);
    wr(A_CON2, 8'h04);
    rd(A_CON2, 8'h01);
    wait_irq();
    rd(A_CON2, 8'h00);
    wr(A_IRQ_EN, 8'h00);
    rd(A_IRQ_STS, 8'h01);
    `CHK(irq, 1'b0)
    wr(A_IRQ_EN, 8'h01);
    rd(A_IRQ_STS, 8'h01);
    `CHK(irq, 1'b1)
    wr(A_IRQ_CLR, 8'h01);
    rd(A_IRQ_STS, 8'h00);
    `CHK(irq, 1'b0)
    $display("test start and interrupt done");
    mon_clr();
    wr(A_BUF, 8'hA5);
    wr(A_BUF, 8'h77);
    rd(A_CON1, 8'hA8);
    rd(A_IRQ_STS, 8'h02);
    wait_irq();
    rd(A_BUF, 8'hA5);
    rd(A_CON2, 8'h00);
    `CHK(slv_rx, 8'hA5)
    `CHK(min_hi >= 8, 1'b1)
    // high half restarts only once the filtered line reads high: up to 7 cycles extra
    `CHK(min_per >= 16 && max_per <= 23, 1'b1)
    bad = 0;
    repeat (40) @(posedge pclk) if (scl_w !== 1'b0) bad++;
    `CHK(bad, 0)
    wr(A_CON1, 8'h28);
    wr(A_IRQ_CLR, 8'h03);
    rd(A_CON1, 8'h28);
    $display("test byte and collision done");
    stretch <= 8'd20;
    mon_clr();
    wr(A_BUF, 8'h3C);
    wait_irq();
    `CHK(slv_rx, 8'h3C)
    `CHK(min_lo >= 20, 1'b1)
    `CHK(min_hi >= 8, 1'b1)
    wr(A_IRQ_CLR, 8'h03);
    stretch <= 8'h00;
    wr(A_CON2, 8'h04);
    wait_irq();
    `CHK({scl_w, sda_w}, 2'b11)
    apb(1'b0, A_STATUS, 8'h00);
    `CHK(r[STAT_P], 1'b1)
    wr(A_IRQ_CLR, 8'h03);
    $display("test stretch and stop done");
    wr(A_CON2, 8'h01);
    wait_irq();
    wr(A_IRQ_CLR, 8'h03);
    wr(A_CON2, 8'h08);
    wait_irq();
    rd(A_STATUS, 8'h09);
    rd(A_BUF, 8'hFF);
    rd(A_STATUS, 8'h08);
    wr(A_IRQ_CLR, 8'h03);
    wr(A_CON2, 8'h30);
    wait_irq();
    rd(A_CON2, 8'h20);
    wr(A_IRQ_CLR, 8'h03);
    wr(A_CON2, 8'h22);
    wait_irq();
    rd(A_CON2, 8'h20);
    rd(A_STATUS, 8'h08);
    `CHK({scl_w, sda_w}, 2'b00)
    wr(A_IRQ_CLR, 8'h03);
    $display("test receive, ack and restart done");
    spi <= 1'b1;
    wr(A_CON1, 8'h2A);
    mon_clr();
    wr(A_BUF, 8'h5A);
    wait_irq();
    rd(A_BUF, 8'h5A);
    `CHK(min_per, 16)
    `CHK(max_per, 16)
    $display("test spi done");
    final_report();
  end
endmodule
